// ### rtl/nfcs_host.sv
// Host-side NOR flash command sequencer: turns user orders into the flash's
// multi-cycle write sequences and drives its asynchronous bus pins.
// Assumes the flash is wired to the pins below and that byte_mode matches
// the flash's word/byte strap.
//
// Operation
// R1 - Program: three unlock/command cycles, then target write
// R2 - Buffer: unlock, 25h, count-1, words, 29h confirm
// R3 - Abort reset: two unlock cycles then F0h
// R4 - Erase: six cycles, 10h chip, 30h sector
// R5 - Query entry: 98h at 55h word, AAh byte
// R6 - Suspend B0h, resume 30h, any address
// R7 - Deep power-down: unlock plus B9h; exit ABh
// R8 - Lock register: entry 40h, A0h program, 90h/00h exit
// R9 - Persistent guards: C0h entry, set, erase, exit
// R10 - Freeze mode: 50h entry, A0h/00h set, exit
// R11 - Guard status reads: 00h locked, 01h unlocked
// R12 - Query mode left only by F0h reset
// R13 - Host sends only defined command codes
// R14 - Mismatched write abandons a partial sequence
// R15 - Byte mode shifts command addresses left one
`default_nettype none
`include "nfcs_map.svh"

module nfcs_host
  import nfcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // User orders
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire nfcs_cmd_t cmd,
  input wire logic byte_mode,
  // User results
  output logic cmd_done,
  output logic [`NFCS_DQ_W-1:0] rd_data,
  output logic guard_unlocked,
  // Flash pins
  output nfcs_pins_t pins,
  input wire logic [`NFCS_DQ_W-1:0] dq_i
);

  typedef enum logic {
    NFCS_M_IDLE = 1'b0,
    NFCS_M_BUSY = 1'b1
  } nfcs_m_state_t;

  nfcs_m_state_t state, next_state;
  nfcs_cmd_t cur, next_cur;
  logic [2:0] idx, next_idx;
  logic go, next_go;
  logic done_q, next_done_q;
  logic [`NFCS_DQ_W-1:0] next_rd_data;
  logic next_guard_unlocked;
  logic byte_q, next_byte_q;
  logic cyc_done;
  logic [`NFCS_DQ_W-1:0] cyc_rdata;
  nfcs_step_t step;

  // R15 byte mode shift
  function automatic logic [`NFCS_ADDR_W-1:0] cmd_addr(
    input logic [`NFCS_ADDR_W-1:0] a, input logic bm);
    cmd_addr = bm ? {a[`NFCS_ADDR_W-2:0], 1'b0} : a;
  endfunction : cmd_addr

  // Sequence table: bus cycle number i of order c
  function automatic nfcs_step_t step_of(input nfcs_cmd_t c,
                                         input logic [2:0] i,
                                         input logic bm);
    nfcs_step_t s;
    logic [`NFCS_ADDR_W-1:0] u1, u2;
    u1 = cmd_addr(`NFCS_A_UNLOCK1, bm);
    // R15 second unlock in byte mode is 555h, not a shifted 2AAh
    u2 = bm ? `NFCS_A_UNLOCK2_BYTE : `NFCS_A_UNLOCK2;
    s = '{addr: `NFCS_A_ANY, data: `NFCS_D_ZERO, rd: 1'b0, last: 1'b0};
    // Orders starting with the two unlock cycles share them
    if (i == 3'd0) begin
      s.addr = u1;
      s.data = `NFCS_D_UNLOCK1;
    end else if (i == 3'd1) begin
      s.addr = u2;
      s.data = `NFCS_D_UNLOCK2;
    end
    // R13 only table codes
    unique case (c.op)
      NFCS_OP_PROGRAM: begin
        // R1 program sequence
        if (i == 3'd2) s = '{u1, `NFCS_D_PROGRAM, 1'b0, 1'b0};
        if (i == 3'd3) s = '{c.addr, c.data, 1'b0, 1'b1};
      end
      NFCS_OP_BUF_LOAD: begin
        // R2 buffer setup, data carries count minus one
        if (i == 3'd2) s = '{c.addr, `NFCS_D_BUF_LOAD, 1'b0, 1'b0};
        if (i == 3'd3) s = '{c.addr, c.data, 1'b0, 1'b1};
      end
      // R2 buffer word
      NFCS_OP_BUF_WORD: s = '{c.addr, c.data, 1'b0, 1'b1};
      // R2 confirm starts programming
      NFCS_OP_BUF_CONFIRM: s = '{c.addr, `NFCS_D_BUF_CONFIRM, 1'b0, 1'b1};
      NFCS_OP_ABORT_RESET: begin
        // R3 abort reset
        if (i == 3'd2) s = '{u1, `NFCS_D_RESET, 1'b0, 1'b1};
      end
      NFCS_OP_CHIP_ERASE, NFCS_OP_SECTOR_ERASE: begin
        // R4 six-cycle erase
        if (i == 3'd2) s = '{u1, `NFCS_D_ERASE_SETUP, 1'b0, 1'b0};
        if (i == 3'd3) s = '{u1, `NFCS_D_UNLOCK1, 1'b0, 1'b0};
        if (i == 3'd4) s = '{u2, `NFCS_D_UNLOCK2, 1'b0, 1'b0};
        if (i == 3'd5) begin
          s = (c.op == NFCS_OP_CHIP_ERASE) ?
              nfcs_step_t'{u1, `NFCS_D_CHIP_ERASE, 1'b0, 1'b1} :
              nfcs_step_t'{c.addr, `NFCS_D_SECTOR_ERASE, 1'b0, 1'b1};
        end
      end
      // R5 query entry
      NFCS_OP_QUERY_ENTER:
        s = '{cmd_addr(`NFCS_A_QUERY, bm), `NFCS_D_QUERY, 1'b0, 1'b1};
      // R12 reset leaves query mode
      NFCS_OP_RESET: s = '{`NFCS_A_ANY, `NFCS_D_RESET, 1'b0, 1'b1};
      // R6 suspend and resume
      NFCS_OP_SUSPEND: s = '{`NFCS_A_ANY, `NFCS_D_SUSPEND, 1'b0, 1'b1};
      NFCS_OP_RESUME: s = '{`NFCS_A_ANY, `NFCS_D_RESUME, 1'b0, 1'b1};
      NFCS_OP_DPD_ENTER: begin
        // R7 deep power-down entry
        if (i == 3'd2) s = '{`NFCS_A_ANY, `NFCS_D_DPD_ENTER, 1'b0, 1'b1};
      end
      // R7 deep power-down exit
      NFCS_OP_DPD_EXIT: s = '{`NFCS_A_ANY, `NFCS_D_DPD_EXIT, 1'b0, 1'b1};
      NFCS_OP_LOCK_ENTER: begin
        // R8 lock register entry
        if (i == 3'd2) s = '{u1, `NFCS_D_LOCK_ENTRY, 1'b0, 1'b1};
      end
      NFCS_OP_GUARD_ENTER: begin
        // R9 persistent guard entry
        if (i == 3'd2) s = '{u1, `NFCS_D_GUARD_ENTRY, 1'b0, 1'b1};
      end
      NFCS_OP_FREEZE_ENTER: begin
        // R10 freeze mode entry
        if (i == 3'd2) s = '{u1, `NFCS_D_FREEZE_ENTRY, 1'b0, 1'b1};
      end
      NFCS_OP_LOCK_PROGRAM, NFCS_OP_GUARD_SET, NFCS_OP_FREEZE_SET: begin
        // R8 R9 R10 A0h then data
        s = '{`NFCS_A_ANY, `NFCS_D_PROGRAM, 1'b0, 1'b0};
        if (i == 3'd1) begin
          s.last = 1'b1;
          s.addr = (c.op == NFCS_OP_GUARD_SET) ? c.addr : `NFCS_A_ANY;
          s.data = (c.op == NFCS_OP_LOCK_PROGRAM) ? c.data : `NFCS_D_ZERO;
        end
      end
      NFCS_OP_GUARD_ERASE: begin
        // R9 erase all guards
        s = '{`NFCS_A_ANY, `NFCS_D_ERASE_SETUP, 1'b0, 1'b0};
        if (i == 3'd1) s = '{`NFCS_A_ANY, `NFCS_D_SECTOR_ERASE, 1'b0, 1'b1};
      end
      NFCS_OP_MODE_EXIT: begin
        // R8 R9 R10 exit 90h/00h
        s = '{`NFCS_A_ANY, `NFCS_D_MODE_EXIT, 1'b0, 1'b0};
        if (i == 3'd1) s = '{`NFCS_A_ANY, `NFCS_D_ZERO, 1'b0, 1'b1};
      end
      NFCS_OP_READ: s = '{c.addr, `NFCS_D_ZERO, 1'b1, 1'b1};
      // Unknown codes end after one read cycle at address 0; nothing is written
      default: s = '{`NFCS_A_ANY, `NFCS_D_ZERO, 1'b1, 1'b1};
    endcase
    step_of = s;
  endfunction : step_of

  assign step = step_of(cur, idx, byte_q);
  // Orders are taken only between sequences, so none interleave
  assign cmd_ready = (state == NFCS_M_IDLE);
  assign cmd_done = done_q;

  // Order sequencing: one bus cycle after another until the last
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_idx = idx;
    next_go = 1'b0;
    next_done_q = 1'b0;
    next_rd_data = rd_data;
    next_guard_unlocked = guard_unlocked;
    next_byte_q = byte_q;
    unique case (state)
      NFCS_M_IDLE: begin
        if (cmd_valid) begin
          next_state = NFCS_M_BUSY;
          next_cur = cmd;
          next_idx = 3'd0;
          next_go = 1'b1;
          next_byte_q = byte_mode;
        end
      end
      NFCS_M_BUSY: begin
        if (cyc_done) begin
          if (step.last) begin
            next_state = NFCS_M_IDLE;
            next_done_q = 1'b1;
            if (step.rd) begin
              next_rd_data = cyc_rdata;
              // R11 01h means unprotected
              next_guard_unlocked =
                (cyc_rdata[7:0] == `NFCS_D_GUARD_UNLOCKED);
            end
          end else begin
            next_idx = idx + 3'd1;
            next_go = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= NFCS_M_IDLE;
      cur <= '{op: NFCS_OP_READ, addr: '0, data: '0};
      idx <= 3'd0;
      go <= 1'b0;
      done_q <= 1'b0;
      rd_data <= '0;
      guard_unlocked <= 1'b0;
      byte_q <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      idx <= next_idx;
      go <= next_go;
      done_q <= next_done_q;
      rd_data <= next_rd_data;
      guard_unlocked <= next_guard_unlocked;
      byte_q <= next_byte_q;
    end
  end

  // Bus cycle engine
  nfcs_bus_cycle u_cycle (
    .clk(clk),
    .arst_n(arst_n),
    .start(go),
    .step(step),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins),
    .dq_i(dq_i)
  );

endmodule : nfcs_host

`default_nettype wire

// ### include/nfcs_map.svh
// Constants of the NOR flash command sequencer host: addresses, codes, timing.
// Assumes a 20 MHz controller clock and a word-mode flash bus.
`ifndef NFCS_MAP_SVH
`define NFCS_MAP_SVH

// Bus widths
`define NFCS_ADDR_W 22
`define NFCS_DQ_W 16

// Word-mode command addresses; byte mode shifts them left by one
`define NFCS_A_UNLOCK1 22'h000555
`define NFCS_A_UNLOCK2 22'h0002aa
// Byte-mode second unlock sets the low bit, so it is not a plain shift
`define NFCS_A_UNLOCK2_BYTE 22'h000555
`define NFCS_A_QUERY 22'h000055
`define NFCS_A_ANY 22'h000000

// Command and data codes
`define NFCS_D_UNLOCK1 16'h00aa
`define NFCS_D_UNLOCK2 16'h0055
`define NFCS_D_PROGRAM 16'h00a0
`define NFCS_D_BUF_LOAD 16'h0025
`define NFCS_D_BUF_CONFIRM 16'h0029
`define NFCS_D_RESET 16'h00f0
`define NFCS_D_ERASE_SETUP 16'h0080
`define NFCS_D_CHIP_ERASE 16'h0010
`define NFCS_D_SECTOR_ERASE 16'h0030
`define NFCS_D_QUERY 16'h0098
`define NFCS_D_SUSPEND 16'h00b0
`define NFCS_D_RESUME 16'h0030
`define NFCS_D_DPD_ENTER 16'h00b9
`define NFCS_D_DPD_EXIT 16'h00ab
`define NFCS_D_LOCK_ENTRY 16'h0040
`define NFCS_D_GUARD_ENTRY 16'h00c0
`define NFCS_D_FREEZE_ENTRY 16'h0050
`define NFCS_D_MODE_EXIT 16'h0090
`define NFCS_D_ZERO 16'h0000
`define NFCS_D_GUARD_UNLOCKED 8'h01

// Timing: times in ns, counts in 20 MHz cycles (least times round up)
`define NFCS_CLK_MHZ 20
`define NFCS_T_WE_NS 50
`define NFCS_T_ACC_NS 100
`define NFCS_WE_CYC ((`NFCS_T_WE_NS * `NFCS_CLK_MHZ + 999) / 1000)
`define NFCS_ACC_CYC ((`NFCS_T_ACC_NS * `NFCS_CLK_MHZ + 999) / 1000)
`define NFCS_SYNC_CYC 2

`endif

// ### include/nfcs_pkg.sv
// Types shared by the NOR flash command sequencer host.
// Assumes nfcs_map.svh is on the include path.
`default_nettype none
`include "nfcs_map.svh"

package nfcs_pkg;

  // Operations the user can order
  typedef enum logic [4:0] {
    NFCS_OP_PROGRAM = 5'h00,
    NFCS_OP_BUF_LOAD = 5'h01,
    NFCS_OP_BUF_WORD = 5'h02,
    NFCS_OP_BUF_CONFIRM = 5'h03,
    NFCS_OP_ABORT_RESET = 5'h04,
    NFCS_OP_CHIP_ERASE = 5'h05,
    NFCS_OP_SECTOR_ERASE = 5'h06,
    NFCS_OP_QUERY_ENTER = 5'h07,
    NFCS_OP_RESET = 5'h08,
    NFCS_OP_SUSPEND = 5'h09,
    NFCS_OP_RESUME = 5'h0a,
    NFCS_OP_DPD_ENTER = 5'h0b,
    NFCS_OP_DPD_EXIT = 5'h0c,
    NFCS_OP_LOCK_ENTER = 5'h0d,
    NFCS_OP_LOCK_PROGRAM = 5'h0e,
    NFCS_OP_GUARD_ENTER = 5'h0f,
    NFCS_OP_GUARD_SET = 5'h10,
    NFCS_OP_GUARD_ERASE = 5'h11,
    NFCS_OP_FREEZE_ENTER = 5'h12,
    NFCS_OP_FREEZE_SET = 5'h13,
    NFCS_OP_MODE_EXIT = 5'h14,
    NFCS_OP_READ = 5'h15
  } nfcs_op_t;

  // One user order
  typedef struct packed {
    nfcs_op_t op;
    logic [`NFCS_ADDR_W-1:0] addr;
    logic [`NFCS_DQ_W-1:0] data;
  } nfcs_cmd_t;

  // One flash bus cycle of a sequence
  typedef struct packed {
    logic [`NFCS_ADDR_W-1:0] addr;
    logic [`NFCS_DQ_W-1:0] data;
    logic rd;
    logic last;
  } nfcs_step_t;

  // Pins toward the flash; dq_oe high while the host drives the data bus
  typedef struct packed {
    logic [`NFCS_ADDR_W-1:0] addr;
    logic [`NFCS_DQ_W-1:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } nfcs_pins_t;

endpackage : nfcs_pkg

`default_nettype wire

// ### rtl/nfcs_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, paced by the clock.
// Assumes the flash answers reads within the access time in the map.
`default_nettype none
`include "nfcs_map.svh"

module nfcs_bus_cycle
  import nfcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Cycle request
  input wire logic start,
  input wire nfcs_step_t step,
  output logic done,
  output logic [`NFCS_DQ_W-1:0] rdata,
  // Flash pins
  output nfcs_pins_t pins,
  input wire logic [`NFCS_DQ_W-1:0] dq_i
);

  typedef enum logic [1:0] {
    NFCS_BC_IDLE = 2'b00,
    NFCS_BC_SETUP = 2'b01,
    NFCS_BC_PULSE = 2'b11,
    NFCS_BC_HOLD = 2'b10
  } nfcs_bc_state_t;

  localparam logic [3:0] WE_CYC = 4'(`NFCS_WE_CYC);
  // Reads wait out the access time plus the pin synchroniser
  localparam logic [3:0] RD_CYC = 4'(`NFCS_ACC_CYC + `NFCS_SYNC_CYC);

  nfcs_bc_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  nfcs_pins_t next_pins;
  logic [`NFCS_DQ_W-1:0] next_rdata;
  logic [`NFCS_DQ_W-1:0] dq_meta, dq_sync;

  // Data pins come from outside the clock domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_meta <= '0;
      dq_sync <= '0;
    end else begin
      dq_meta <= dq_i;
      dq_sync <= dq_meta;
    end
  end

  // Setup, strobe pulse, hold; address and data stand through all three
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pins = pins;
    next_rdata = rdata;
    done = 1'b0;
    unique case (state)
      NFCS_BC_IDLE: begin
        if (start) begin
          next_state = NFCS_BC_SETUP;
          next_pins.addr = step.addr;
          next_pins.dq_o = step.data;
          next_pins.dq_oe = !step.rd;
          next_pins.ce_n = 1'b0;
        end
      end
      NFCS_BC_SETUP: begin
        next_state = NFCS_BC_PULSE;
        next_cnt = pins.dq_oe ? WE_CYC : RD_CYC;
        next_pins.we_n = !pins.dq_oe;
        next_pins.oe_n = pins.dq_oe;
      end
      NFCS_BC_PULSE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_state = NFCS_BC_HOLD;
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          if (!pins.dq_oe) begin
            next_rdata = dq_sync;
          end
        end
      end
      NFCS_BC_HOLD: begin
        // Flash latches data on the rising strobe, so drive one more cycle
        next_state = NFCS_BC_IDLE;
        next_pins.ce_n = 1'b1;
        next_pins.dq_oe = 1'b0;
        done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= NFCS_BC_IDLE;
      cnt <= 4'h0;
      pins <= '{addr: '0, dq_o: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                oe_n: 1'b1};
      rdata <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
      rdata <= next_rdata;
    end
  end

endmodule : nfcs_bus_cycle

`default_nettype wire

// ### bench/nfcs_host_monitor.sv
// Assertion checker for the NOR flash command sequencer host.
// Sees only the host's ports; attached by the bind at the foot.
`default_nettype none
`include "nfcs_map.svh"

module nfcs_host_monitor
  import nfcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // User side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire nfcs_cmd_t cmd,
  input wire logic byte_mode,
  input wire logic cmd_done,
  input wire logic [`NFCS_DQ_W-1:0] rd_data,
  input wire logic guard_unlocked,
  // Flash side
  input wire nfcs_pins_t pins,
  input wire logic [`NFCS_DQ_W-1:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Order accepted at this edge
  sequence s_take(nfcs_op_t o);
    cmd_valid && cmd_ready && cmd.op == o;
  endsequence
  // One write of F0h to address 0, its strobe, then done
  sequence s_reset_walk;
    ##2 (pins.addr == `NFCS_A_ANY && pins.dq_o == `NFCS_D_RESET && pins.dq_oe)
    ##1 !pins.we_n ##1 pins.we_n ##1 cmd_done;
  endsequence

  AST_RESET_WALK: assert property (
    s_take(NFCS_OP_RESET) |-> s_reset_walk) else $error("reset walk wrong");
  AST_QUERY_ADDR: assert property (
    s_take(NFCS_OP_QUERY_ENTER) |-> ##3 pins.dq_o == `NFCS_D_QUERY &&
    pins.addr == (`NFCS_A_QUERY << $past(byte_mode, 3)))
    else $error("query entry cycle wrong");
  AST_PROG_UNLOCK: assert property (
    s_take(NFCS_OP_PROGRAM) |-> ##3 pins.dq_o == `NFCS_D_UNLOCK1 &&
    pins.addr == (`NFCS_A_UNLOCK1 << $past(byte_mode, 3)) ##6
    pins.dq_o == `NFCS_D_UNLOCK2 &&
    pins.addr == ($past(byte_mode, 9) ? `NFCS_A_UNLOCK2_BYTE :
    `NFCS_A_UNLOCK2))
    else $error("unlock cycles wrong");
  AST_SUSPEND: assert property (
    s_take(NFCS_OP_SUSPEND) |-> ##3 pins.dq_o == `NFCS_D_SUSPEND &&
    pins.addr == `NFCS_A_ANY) else $error("suspend cycle wrong");
  AST_GUARD_FLAG: assert property (
    guard_unlocked == (rd_data[7:0] == `NFCS_D_GUARD_UNLOCKED))
    else $error("guard flag disagrees with read data");
  AST_WE_IN_CE: assert property (
    !pins.we_n |-> !pins.ce_n && pins.dq_oe && pins.oe_n)
    else $error("write strobe outside select");
  AST_WE_PULSE: assert property (
    $fell(pins.we_n) |=> pins.we_n && !pins.ce_n ##1 pins.ce_n && !pins.dq_oe)
    else $error("write strobe shape wrong");
  AST_HOLD: assert property (
    !pins.we_n |=> $stable(pins.addr) && $stable(pins.dq_o))
    else $error("address or data moved at strobe end");
  AST_READ_PULSE: assert property (
    $fell(pins.oe_n) |-> (!pins.oe_n && !pins.dq_oe) [*4] ##1 pins.oe_n)
    else $error("read pulse wrong");
  AST_BUSY: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready [*4])
    else $error("order taken while busy");
  AST_DONE: assert property (
    cmd_done |-> cmd_ready ##1 !cmd_done) else $error("done not a pulse");
  AST_IDLE: assert property (
    cmd_ready |-> pins.ce_n && pins.we_n && pins.oe_n)
    else $error("pins busy while idle");
endmodule : nfcs_host_monitor

bind nfcs_host nfcs_host_monitor nfcs_host_monitor_inst (
  .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd(cmd), .byte_mode(byte_mode), .cmd_done(cmd_done), .rd_data(rd_data),
  .guard_unlocked(guard_unlocked), .pins(pins), .dq_i(dq_i));

`default_nettype wire

// ### bench/nfcs_flash_model.sv
// Behavioural flash on the far side of the host pins.
// Logs every write strobe made with ce_n low for the bench; answers reads from guard state in guard mode, else with the inverted address.
`default_nettype none
`include "nfcs_map.svh"

module nfcs_flash_model
  import nfcs_pkg::*;
(
  // Pins from the host
  input wire nfcs_pins_t pins,
  // Data bus level seen by the host
  output logic [`NFCS_DQ_W-1:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`NFCS_ADDR_W-1:0] wa[$];
  logic [`NFCS_DQ_W-1:0] wd[$];
  logic [7:0] p1 = 8'h0;
  logic [7:0] p2 = 8'h0;
  logic guard_mode = 1'b0;
  logic guard_set = 1'b0;
  logic [`NFCS_DQ_W-1:0] rv;
  logic [`NFCS_DQ_W-1:0] last_rv = 16'h0;

  // decode on the last two data bytes; only strobes with ce_n low are logged
  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      wa.push_back(pins.addr);
      wd.push_back(pins.dq_o);
      if (p2 == 8'haa && p1 == 8'h55 && pins.dq_o[7:0] == 8'hc0)
        guard_mode = 1'b1;
      else if (guard_mode && p1 == 8'ha0)
        guard_set = 1'b1;
      else if (guard_mode && p1 == 8'h80 && pins.dq_o[7:0] == 8'h30)
        guard_set = 1'b0;
      else if (guard_mode && p1 == 8'h90)
        guard_mode = 1'b0;
      p2 = p1;
      p1 = pins.dq_o[7:0];
    end
  end

  always_comb rv = guard_mode ? {15'h0, !guard_set} : ~pins.addr[15:0];
  // Released bus shows the inverse of the last read, never a held copy
  always @(posedge pins.oe_n) last_rv = rv;
  assign dq_i = pins.dq_oe ? pins.dq_o :
                (!pins.ce_n && !pins.oe_n) ? rv : ~last_rv;
endmodule : nfcs_flash_model

`default_nettype wire

// ### bench/nfcs_host_tb_top.sv
// Self-checking bench for the NOR flash command sequencer host.
// Assumes the behavioural flash model logs every write strobe made with ce_n low.
`default_nettype none
`include "nfcs_map.svh"

module nfcs_host_tb_top
  import nfcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // One row: order, cycle count, last bus cycle and prior cycle's data
  typedef struct {
    nfcs_op_t op;
    logic [21:0] a;
    logic [15:0] d;
    logic bm;
    int n;
    logic [21:0] la;
    logic [15:0] ld;
    logic [15:0] pd;
  } nfcs_row_t;
  logic clk, arst_n, cmd_valid, cmd_ready, byte_mode, cmd_done;
  logic guard_unlocked;
  logic [15:0] rd_data, dq_i;
  nfcs_cmd_t cmd;
  nfcs_pins_t pins;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  nfcs_row_t rows[21] = '{
    '{NFCS_OP_PROGRAM, 22'h1234, 16'hbeef, 1'h0, 4, 22'h1234, 16'hbeef, 16'ha0},
    '{NFCS_OP_BUF_LOAD, 22'h8000, 16'h0, 1'h0, 4, 22'h8000, 16'h0, 16'h25},
    '{NFCS_OP_BUF_WORD, 22'h8003, 16'h1111, 1'h0, 1, 22'h8003, 16'h1111, 16'h0},
    '{NFCS_OP_BUF_CONFIRM, 22'h8000, 16'h0, 1'h0, 1, 22'h8000, 16'h29, 16'h0},
    '{NFCS_OP_ABORT_RESET, 22'h0, 16'h0, 1'h1, 3, 22'haaa, 16'hf0, 16'h55},
    '{NFCS_OP_CHIP_ERASE, 22'h0, 16'h0, 1'h0, 6, 22'h555, 16'h10, 16'h55},
    '{NFCS_OP_SECTOR_ERASE, 22'h8000, 16'h0, 1'h1, 6, 22'h8000, 16'h30, 16'h55},
    '{NFCS_OP_QUERY_ENTER, 22'h0, 16'h0, 1'h0, 1, 22'h55, 16'h98, 16'h0},
    '{NFCS_OP_QUERY_ENTER, 22'h0, 16'h0, 1'h1, 1, 22'haa, 16'h98, 16'h0},
    '{NFCS_OP_RESET, 22'h0, 16'h0, 1'h0, 1, 22'h0, 16'hf0, 16'h0},
    '{NFCS_OP_SUSPEND, 22'h0, 16'h0, 1'h0, 1, 22'h0, 16'hb0, 16'h0},
    '{NFCS_OP_RESUME, 22'h0, 16'h0, 1'h0, 1, 22'h0, 16'h30, 16'h0},
    '{NFCS_OP_DPD_ENTER, 22'h0, 16'h0, 1'h0, 3, 22'h0, 16'hb9, 16'h55},
    '{NFCS_OP_DPD_EXIT, 22'h0, 16'h0, 1'h0, 1, 22'h0, 16'hab, 16'h0},
    '{NFCS_OP_LOCK_ENTER, 22'h0, 16'h0, 1'h0, 3, 22'h555, 16'h40, 16'h55},
    '{NFCS_OP_LOCK_PROGRAM, 22'h0, 16'h5a, 1'h0, 2, 22'h0, 16'h5a, 16'ha0},
    '{NFCS_OP_MODE_EXIT, 22'h0, 16'h0, 1'h0, 2, 22'h0, 16'h0, 16'h90},
    '{NFCS_OP_FREEZE_ENTER, 22'h0, 16'h0, 1'h0, 3, 22'h555, 16'h50, 16'h55},
    '{NFCS_OP_FREEZE_SET, 22'h0, 16'h0, 1'h0, 2, 22'h0, 16'h0, 16'ha0},
    '{NFCS_OP_GUARD_ENTER, 22'h0, 16'h0, 1'h0, 3, 22'h555, 16'hc0, 16'h55},
    '{NFCS_OP_GUARD_SET, 22'h9000, 16'h0, 1'h0, 2, 22'h9000, 16'h0, 16'ha0}};

  nfcs_host nfcs_host_inst (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .byte_mode(byte_mode),
    .cmd_done(cmd_done), .rd_data(rd_data),
    .guard_unlocked(guard_unlocked), .pins(pins), .dq_i(dq_i));
  nfcs_flash_model nfcs_flash_model_inst (.pins(pins), .dq_i(dq_i));

  // Clock and a hang guard well above the expected run
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Logged bus cycle i as {addr, data}
  function automatic logic [39:0] lg(input int i);
    return {nfcs_flash_model_inst.wa[i], nfcs_flash_model_inst.wd[i]};
  endfunction : lg

  task automatic clr();
    nfcs_flash_model_inst.wa.delete();
    nfcs_flash_model_inst.wd.delete();
  endtask : clr

  // Offer at a falling edge, wait for done; returns in the done cycle
  task automatic run(input nfcs_op_t op, input logic [21:0] a,
                     input logic [15:0] d, input logic bm);
    int k;
    k = 0;
    cmd_valid = 1'b1;
    cmd = '{op, a, d};
    byte_mode = bm;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("cmd_done", 40'h1, {39'h0, cmd_done});
  endtask : run

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    byte_mode = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset pins", 40'h1e, {cmd_ready, pins.ce_n, pins.we_n, pins.oe_n,
        pins.dq_oe});
    chk("reset read", 40'h0, {rd_data, guard_unlocked});
    $display("test reset done");
    arst_n = 1'b1;
    @(negedge clk);
    // Table rows, offered back to back
    foreach (rows[i]) begin
      clr();
      run(rows[i].op, rows[i].a, rows[i].d, rows[i].bm);
      chk("cycles", rows[i].n, nfcs_flash_model_inst.wa.size());
      chk("last", {rows[i].la, rows[i].ld}, lg(rows[i].n - 1));
      if (rows[i].n > 1) begin
        chk("prior", rows[i].pd, lg(rows[i].n - 2) & 16'hffff);
      end
      if (rows[i].n > 2) begin
        chk("unlock1", {22'h555 << rows[i].bm, 16'haa}, lg(0));
        chk("unlock2", {rows[i].bm ? 22'h555 : 22'h2aa, 16'h55}, lg(1));
      end
      $display("row %0d done", i);
    end
    run(NFCS_OP_READ, 22'h9000, 16'h0, 1'h0);
    @(negedge clk);
    chk("guard read set", 40'h0, {rd_data, guard_unlocked});
    clr();
    run(NFCS_OP_GUARD_ERASE, 22'h0, 16'h0, 1'h0);
    chk("erase cycles", 40'h2, nfcs_flash_model_inst.wa.size());
    chk("guard erase 1", {22'h0, 16'h80}, lg(0));
    chk("guard erase 2", {22'h0, 16'h30}, lg(1));
    run(NFCS_OP_READ, 22'h9000, 16'h0, 1'h0);
    @(negedge clk);
    chk("guard read clear", {16'h1, 1'h1}, {rd_data, guard_unlocked});
    run(NFCS_OP_MODE_EXIT, 22'h0, 16'h0, 1'h0);
    run(NFCS_OP_READ, 22'h123, 16'h0, 1'h0);
    @(negedge clk);
    chk("array read", {16'hfedc, 1'h0}, {rd_data, guard_unlocked});
    $display("test guard reads done");
    // Offers while busy are ignored
    clr();
    cmd_valid = 1'b1;
    cmd = '{NFCS_OP_DPD_EXIT, 22'h0, 16'h0};
    @(negedge clk);
    cmd = '{NFCS_OP_SUSPEND, 22'h0, 16'h0};
    repeat (4) @(negedge clk);
    cmd_valid = 1'b0;
    repeat (6) @(negedge clk);
    chk("refused", 40'h1, nfcs_flash_model_inst.wa.size());
    chk("taken", {22'h0, 16'hab}, lg(0));
    $display("test refused offers done");
    // Reset in mid order leaves pins idle
    cmd_valid = 1'b1;
    cmd = '{NFCS_OP_PROGRAM, 22'h40, 16'h1};
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    chk("mid reset pins", 40'h1e, {cmd_ready, pins.ce_n, pins.we_n,
        pins.oe_n, pins.dq_oe});
    arst_n = 1'b1;
    @(negedge clk);
    clr();
    run(NFCS_OP_RESET, 22'h0, 16'h0, 1'h0);
    chk("after reset", {22'h0, 16'hf0}, lg(0));
    $display("test mid reset done");
    close_out();
  end
endmodule : nfcs_host_tb_top

`default_nettype wire
